/* File: frl_pkg.sv */
package frl_pkg;

    // timing
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned RAMP_UNIT_MS = 100;
    localparam int unsigned FILT_UNIT_US = 100;
    localparam int unsigned CYC_PER_TENTH = CLK_HZ / 1000 * RAMP_UNIT_MS;
    localparam int unsigned CYC_PER_FILT = CLK_HZ / 1_000_000 * FILT_UNIT_US;

    // limits, times in 0.1 s, frequencies in 0.01 Hz, torque in 0.1 %
    localparam logic [15:0] TIME_MIN = 16'h0001;
    localparam logic [15:0] TIME_MAX = 16'h8CA0;
    localparam logic [7:0] PCT_MAX = 8'hC8;
    localparam logic [8:0] PCT_FULL = 9'h064;

    // register word offsets
    localparam logic [7:0] OFS_ESTOP = 8'h10;
    localparam logic [7:0] OFS_JOG = 8'h14;
    localparam logic [7:0] OFS_POLY = 8'h18;
    localparam logic [7:0] OFS_FMAX = 8'h1C;
    localparam logic [7:0] OFS_CRV_ACC = 8'h20;
    localparam logic [7:0] OFS_CRV_DEC = 8'h24;
    localparam logic [7:0] OFS_CHAN = 8'h28;
    localparam logic [7:0] OFS_TDIG = 8'h2C;
    localparam logic [7:0] OFS_PIF = 8'h30;
    localparam logic [7:0] OFS_FILT = 8'h34;
    localparam logic [7:0] OFS_PIH = 8'h38;
    localparam logic [7:0] OFS_PIL = 8'h3C;
    localparam logic [7:0] OFS_STAT = 8'h40;
    localparam logic [7:0] OFS_PIOUT = 8'h44;

    // digit codes
    localparam logic [3:0] CTL_TORQUE = 4'h1;
    localparam logic [3:0] GEN_OFF = 4'h0;
    localparam logic [3:0] GEN_ALWAYS = 4'h1;
    localparam logic [3:0] GEN_CONST = 4'h2;
    localparam logic [3:0] GEN_DECEL = 4'h3;
    localparam logic [3:0] CH_DIG = 4'h0;
    localparam logic [3:0] CH_AI1 = 4'h1;
    localparam logic [3:0] CH_AI2 = 4'h2;
    localparam logic [3:0] CH_AI3 = 4'h3;
    localparam logic [3:0] CH_MIN = 4'h4;
    localparam logic [3:0] CH_MAX = 4'h5;
    localparam logic [3:0] CH_SUB = 4'h6;
    localparam logic [3:0] CH_ADD = 4'h7;
    localparam logic [3:0] CH_PULSE = 4'h8;

    // reset values
    localparam logic [31:0] RST_PAIR = 32'h0064_0064;
    localparam logic [15:0] RST_TIME = 16'h0064;
    localparam logic [15:0] RST_FMAX = 16'h1388;
    localparam logic [23:0] RST_CURVE = 24'h00_3232;
    localparam logic [23:0] RST_CHAN = 24'h99_90_00;
    localparam logic [31:0] RST_TDIG = 32'h05DC_05DC;
    localparam logic [31:0] RST_PIF = 32'h03E8_01F4;
    localparam logic [15:0] RST_FILT = 16'h0096;
    localparam logic [31:0] RST_PI = 32'h00C8_00C8;

    typedef enum logic [1:0] {RAMP_HOLD, RAMP_UP, RAMP_DOWN} frl_ramp_e;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } frl_wb_req_s;

    typedef struct packed {
        logic estop;
        logic jog;
        logic [1:0] time_sel;
        logic mode_toggle;
        logic torque_inhibit;
    } frl_term_s;

    typedef struct packed {
        logic signed [15:0] analog_input_one;
        logic signed [15:0] analog_input_two;
        logic signed [15:0] analog_input_three;
        logic signed [15:0] pulse_frequency_input;
        logic signed [15:0] max_torque;
    } frl_src_s;

    typedef struct packed {
        logic torque_mode;
        logic gen_limit_active;
        logic signed [15:0] motor_ref;
        logic signed [15:0] gen_ref;
        logic signed [15:0] motor_limit;
        logic signed [15:0] gen_limit;
        logic [15:0] kp;
        logic [15:0] ti;
        logic signed [15:0] speed_filt;
    } frl_loop_s;

    typedef struct packed {
        logic [3:0][31:0] pair;
        logic [15:0] estop;
        logic [31:0] jog;
        logic [31:0] poly;
        logic shape;
        logic [15:0] fmax;
        logic [23:0] crv_acc;
        logic [23:0] crv_dec;
        logic [23:0] chan;
        logic [31:0] tdig;
        logic [31:0] pif;
        logic [15:0] filt;
        logic [31:0] pih;
        logic [31:0] pil;
    } frl_cfg_s;

    typedef struct packed {
        frl_cfg_s cfg;
        frl_ramp_e ramp;
        logic [15:0] freq;
        logic [15:0] span_start;
        logic [63:0] err;
        logic [31:0] filt_cnt;
        frl_loop_s loop;
        logic ack;
        logic [31:0] rdat;
    } frl_state_s;

endpackage

/* File: frl_ramp_loop.sv */
`timescale 1ns/10ps
`default_nettype none

// How it works
// - ramp up at fmax per acceleration time
// - ramp down at fmax per deceleration time
// - four time pairs picked by two terminals
// - times clamp to 0.1 s..3600.0 s
// - emergency stop uses its own deceleration time
// - jog uses jog acceleration and deceleration times
// - below polyline accel frequency use pair two
// - below polyline decel frequency use pair two
// - both polyline frequencies zero disables switching
// - shape zero gives constant slope
// - shape one adds start, middle and end curvature
// - curve timing derives from six curve settings
// - ones digit, toggle and inhibit pick mode
// - tens digit picks generative limiting mode
// - unlimited generative torque clamps at maximum torque
// - low and high speed loop gain bands
// - speed feedback low-pass with settable time
// - motoring channel digits pick reference and limit
// - channel codes map to torque sources
// - digital torque setting in 0.1 percent
// - generative channel resets to maximum torque
module frl_ramp_loop #(
    parameter int unsigned CYC_PER_TENTH = frl_pkg::CYC_PER_TENTH,
    parameter int unsigned CYC_PER_FILT = frl_pkg::CYC_PER_FILT
) (
    // system
    input wire logic clock,
    input wire logic rst_n,
    // wishbone slave
    input wire frl_pkg::frl_wb_req_s wb_req,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // terminals and commands
    input wire frl_pkg::frl_term_s term,
    input wire logic [15:0] target_freq,
    input wire frl_pkg::frl_src_s src,
    input wire logic signed [15:0] speed_fb,
    // loop outputs
    output logic [15:0] output_freq,
    output frl_pkg::frl_loop_s loop
);

    localparam frl_pkg::frl_cfg_s CFG_RESET = '{
        pair: {4{frl_pkg::RST_PAIR}},
        estop: frl_pkg::RST_TIME,
        jog: {frl_pkg::RST_TIME, frl_pkg::RST_TIME},
        poly: '0,
        shape: 1'b0,
        fmax: frl_pkg::RST_FMAX,
        crv_acc: frl_pkg::RST_CURVE,
        crv_dec: frl_pkg::RST_CURVE,
        chan: frl_pkg::RST_CHAN,
        tdig: frl_pkg::RST_TDIG,
        pif: frl_pkg::RST_PIF,
        filt: frl_pkg::RST_FILT,
        pih: frl_pkg::RST_PI,
        pil: frl_pkg::RST_PI
    };

    frl_pkg::frl_state_s s;
    frl_pkg::frl_state_s next_s;

    function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
                                           input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
                r[i*8 +: 8] = d[i*8 +: 8];
        end
        return r;
    endfunction

    // time field limits
    function automatic logic [15:0] tclamp(input logic [15:0] t);
        if (t < frl_pkg::TIME_MIN)
            return frl_pkg::TIME_MIN;
        if (t > frl_pkg::TIME_MAX)
            return frl_pkg::TIME_MAX;
        return t;
    endfunction

    function automatic logic [7:0] pclamp(input logic [7:0] p);
        return (p > frl_pkg::PCT_MAX) ? frl_pkg::PCT_MAX : p;
    endfunction

    function automatic logic [23:0] cclamp(input logic [23:0] c);
        return {pclamp(c[23:16]), pclamp(c[15:8]), pclamp(c[7:0])};
    endfunction

    // torque source per channel digit
    function automatic logic signed [15:0] chan_src(input logic [3:0] code,
                                                    input logic signed [15:0] dig,
                                                    input frl_pkg::frl_src_s x);
        logic signed [16:0] t;
        t = '0;
        case (code)
            frl_pkg::CH_DIG: t = 17'(dig);
            frl_pkg::CH_AI1: t = 17'(x.analog_input_one);
            frl_pkg::CH_AI2: t = 17'(x.analog_input_two);
            frl_pkg::CH_AI3: t = 17'(x.analog_input_three);
            frl_pkg::CH_MIN: t = 17'((x.analog_input_one < x.analog_input_two) ?
                                     x.analog_input_one : x.analog_input_two);
            frl_pkg::CH_MAX: t = 17'((x.analog_input_one > x.analog_input_two) ?
                                     x.analog_input_one : x.analog_input_two);
            frl_pkg::CH_SUB: t = 17'(x.analog_input_one) - 17'(x.analog_input_two);
            frl_pkg::CH_ADD: t = 17'(x.analog_input_one) + 17'(x.analog_input_two);
            frl_pkg::CH_PULSE: t = 17'(x.pulse_frequency_input);
            default: t = 17'(x.max_torque);
        endcase
        // keep within the drive's torque capability
        if (t > 17'(x.max_torque))
            t = 17'(x.max_torque);
        if (t < -17'(x.max_torque))
            t = -17'(x.max_torque);
        return t[15:0];
    endfunction

    function automatic logic [15:0] lerp(input logic [15:0] a, input logic [15:0] b,
                                         input logic [15:0] num, input logic [15:0] den);
        logic signed [35:0] r;
        r = $signed(36'(a)) + ($signed(36'(b)) - $signed(36'(a))) * $signed(36'(num)) /
            $signed(36'(den));
        return r[15:0];
    endfunction

    logic [15:0] tgt;
    logic up;
    logic down;
    logic poly_on;
    logic [15:0] t_acc;
    logic [15:0] t_dec;
    logic [15:0] t_use;
    logic [7:0] pct;
    logic [23:0] crv;
    logic [15:0] done_d;
    logic [15:0] total_d;
    logic [63:0] thr;
    logic [63:0] sum;
    logic gen_on;
    logic tmode;
    logic [1:0] idx;

    always_comb
    begin
        next_s = s;
        idx = wb_req.adr[3:2];
        // wishbone: single-cycle ack, write lands with it
        next_s.ack = wb_req.cyc & wb_req.stb & ~s.ack;
        next_s.rdat = '0;
        if (next_s.ack && wb_req.we)
        begin
            case (wb_req.adr)
                frl_pkg::OFS_ESTOP:
                    next_s.cfg.estop = tclamp(16'(wmerge({16'h0, s.cfg.estop}, wb_req.dat,
                                                         wb_req.sel)));
                frl_pkg::OFS_JOG:
                begin
                    next_s.cfg.jog = wmerge(s.cfg.jog, wb_req.dat, wb_req.sel);
                    next_s.cfg.jog = {tclamp(next_s.cfg.jog[31:16]),
                                      tclamp(next_s.cfg.jog[15:0])};
                end
                frl_pkg::OFS_POLY: next_s.cfg.poly = wmerge(s.cfg.poly, wb_req.dat, wb_req.sel);
                frl_pkg::OFS_FMAX:
                    {next_s.cfg.shape, next_s.cfg.fmax} =
                        17'(wmerge({15'h0, s.cfg.shape, s.cfg.fmax}, wb_req.dat, wb_req.sel));
                frl_pkg::OFS_CRV_ACC:
                    next_s.cfg.crv_acc = cclamp(24'(wmerge({8'h0, s.cfg.crv_acc}, wb_req.dat,
                                                           wb_req.sel)));
                frl_pkg::OFS_CRV_DEC:
                    next_s.cfg.crv_dec = cclamp(24'(wmerge({8'h0, s.cfg.crv_dec}, wb_req.dat,
                                                           wb_req.sel)));
                frl_pkg::OFS_CHAN:
                    next_s.cfg.chan = 24'(wmerge({8'h0, s.cfg.chan}, wb_req.dat, wb_req.sel));
                frl_pkg::OFS_TDIG: next_s.cfg.tdig = wmerge(s.cfg.tdig, wb_req.dat, wb_req.sel);
                frl_pkg::OFS_PIF: next_s.cfg.pif = wmerge(s.cfg.pif, wb_req.dat, wb_req.sel);
                frl_pkg::OFS_FILT:
                    next_s.cfg.filt = 16'(wmerge({16'h0, s.cfg.filt}, wb_req.dat, wb_req.sel));
                frl_pkg::OFS_PIH: next_s.cfg.pih = wmerge(s.cfg.pih, wb_req.dat, wb_req.sel);
                frl_pkg::OFS_PIL: next_s.cfg.pil = wmerge(s.cfg.pil, wb_req.dat, wb_req.sel);
                default:
                begin
                    if (wb_req.adr < frl_pkg::OFS_ESTOP)
                    begin
                        next_s.cfg.pair[idx] = wmerge(s.cfg.pair[idx], wb_req.dat, wb_req.sel);
                        next_s.cfg.pair[idx] = {tclamp(next_s.cfg.pair[idx][31:16]),
                                                tclamp(next_s.cfg.pair[idx][15:0])};
                    end
                end
            endcase
        end
        else if (next_s.ack)
        begin
            case (wb_req.adr)
                frl_pkg::OFS_ESTOP: next_s.rdat = {16'h0, s.cfg.estop};
                frl_pkg::OFS_JOG: next_s.rdat = s.cfg.jog;
                frl_pkg::OFS_POLY: next_s.rdat = s.cfg.poly;
                frl_pkg::OFS_FMAX: next_s.rdat = {15'h0, s.cfg.shape, s.cfg.fmax};
                frl_pkg::OFS_CRV_ACC: next_s.rdat = {8'h0, s.cfg.crv_acc};
                frl_pkg::OFS_CRV_DEC: next_s.rdat = {8'h0, s.cfg.crv_dec};
                frl_pkg::OFS_CHAN: next_s.rdat = {8'h0, s.cfg.chan};
                frl_pkg::OFS_TDIG: next_s.rdat = s.cfg.tdig;
                frl_pkg::OFS_PIF: next_s.rdat = s.cfg.pif;
                frl_pkg::OFS_FILT: next_s.rdat = {16'h0, s.cfg.filt};
                frl_pkg::OFS_PIH: next_s.rdat = s.cfg.pih;
                frl_pkg::OFS_PIL: next_s.rdat = s.cfg.pil;
                frl_pkg::OFS_STAT:
                    next_s.rdat = {12'h0, s.loop.gen_limit_active, s.loop.torque_mode,
                                   s.ramp, s.freq};
                frl_pkg::OFS_PIOUT: next_s.rdat = {s.loop.ti, s.loop.kp};
                default:
                begin
                    if (wb_req.adr < frl_pkg::OFS_ESTOP)
                        next_s.rdat = s.cfg.pair[idx];
                end
            endcase
        end

        // emergency stop drives target to zero
        tgt = term.estop ? 16'h0 : ((target_freq > s.cfg.fmax) ? s.cfg.fmax : target_freq);
        up = tgt > s.freq;
        down = tgt < s.freq;
        // polyline off when both thresholds zero
        poly_on = |s.cfg.poly;
        if (term.jog)
            t_acc = s.cfg.jog[15:0];
        else if (poly_on && s.freq < s.cfg.poly[15:0])
            t_acc = s.cfg.pair[1][15:0];
        else
            t_acc = s.cfg.pair[term.time_sel][15:0];
        if (term.estop)
            t_dec = s.cfg.estop;
        else if (term.jog)
            t_dec = s.cfg.jog[31:16];
        else if (poly_on && s.freq < s.cfg.poly[31:16])
            t_dec = s.cfg.pair[1][31:16];
        else
            t_dec = s.cfg.pair[term.time_sel][31:16];
        t_use = up ? t_acc : t_dec;

        next_s.ramp = up ? frl_pkg::RAMP_UP : (down ? frl_pkg::RAMP_DOWN : frl_pkg::RAMP_HOLD);
        if (next_s.ramp != s.ramp)
        begin
            next_s.span_start = s.freq;
            next_s.err = '0;
        end

        // curvature stretches start, middle and end of the span
        crv = up ? s.cfg.crv_acc : s.cfg.crv_dec;
        done_d = up ? s.freq - next_s.span_start : next_s.span_start - s.freq;
        total_d = up ? tgt - next_s.span_start : next_s.span_start - tgt;
        if (done_d * 4 < total_d)
            pct = crv[7:0];
        else if (32'(done_d) * 4 >= 32'(total_d) * 3)
            pct = crv[15:8];
        else
            pct = crv[23:16];
        if (!s.cfg.shape)
            pct = '0;

        // error accumulator, at most one step per clock
        thr = 64'(t_use) * 64'(CYC_PER_TENTH) * 64'(frl_pkg::PCT_FULL + 9'(pct));
        sum = next_s.err + 64'(s.cfg.fmax) * 64'(frl_pkg::PCT_FULL);
        if (next_s.ramp == frl_pkg::RAMP_HOLD)
            next_s.err = '0;
        else if (sum >= thr)
        begin
            next_s.err = sum - thr;
            next_s.freq = up ? s.freq + 16'h1 : s.freq - 16'h1;
        end
        else
            next_s.err = sum;

        tmode = ((s.cfg.chan[3:0] == frl_pkg::CTL_TORQUE) ^ term.mode_toggle) &
                ~term.torque_inhibit;
        case (s.cfg.chan[7:4])
            frl_pkg::GEN_ALWAYS: gen_on = 1'b1;
            frl_pkg::GEN_CONST: gen_on = (next_s.ramp == frl_pkg::RAMP_HOLD);
            frl_pkg::GEN_DECEL: gen_on = (next_s.ramp == frl_pkg::RAMP_DOWN);
            default: gen_on = 1'b0;
        endcase
        next_s.loop.torque_mode = tmode;
        next_s.loop.gen_limit_active = gen_on;
        next_s.loop.motor_ref = tmode ?
            chan_src(s.cfg.chan[11:8], s.cfg.tdig[15:0], src) : '0;
        next_s.loop.motor_limit = chan_src(s.cfg.chan[15:12], s.cfg.tdig[15:0], src);
        next_s.loop.gen_ref = tmode ?
            chan_src(s.cfg.chan[19:16], s.cfg.tdig[31:16], src) : '0;
        // unlimited generative clamps at drive maximum
        next_s.loop.gen_limit = gen_on ?
            chan_src(s.cfg.chan[23:20], s.cfg.tdig[31:16], src) : src.max_torque;

        if (s.freq <= s.cfg.pif[15:0])
            {next_s.loop.ti, next_s.loop.kp} = s.cfg.pil;
        else if (s.freq >= s.cfg.pif[31:16])
            {next_s.loop.ti, next_s.loop.kp} = s.cfg.pih;
        else
        begin
            next_s.loop.kp = lerp(s.cfg.pil[15:0], s.cfg.pih[15:0], s.freq - s.cfg.pif[15:0],
                                  s.cfg.pif[31:16] - s.cfg.pif[15:0]);
            next_s.loop.ti = lerp(s.cfg.pil[31:16], s.cfg.pih[31:16],
                                  s.freq - s.cfg.pif[15:0], s.cfg.pif[31:16] - s.cfg.pif[15:0]);
        end

        // first-order filter, one update per 0.1 ms
        next_s.filt_cnt = (s.filt_cnt >= CYC_PER_FILT - 1) ? '0 : s.filt_cnt + 32'h1;
        if (s.cfg.filt == '0)
            next_s.loop.speed_filt = speed_fb;
        else if (s.filt_cnt >= CYC_PER_FILT - 1)
            next_s.loop.speed_filt = 16'(18'(s.loop.speed_filt) +
                (18'(speed_fb) - 18'(s.loop.speed_filt)) / $signed(18'(s.cfg.filt) + 18'h1));
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s <= '0;
            s.cfg <= CFG_RESET;
            s.loop.kp <= frl_pkg::RST_PI[15:0];
            s.loop.ti <= frl_pkg::RST_PI[31:16];
        end
        else
            s <= next_s;
    end

    assign wb_ack_o = s.ack;
    assign wb_dat_o = s.rdat;
    assign output_freq = s.freq;
    assign loop = s.loop;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);

    property p_one_step;
        (s.freq != $past(s.freq)) |-> (s.freq - $past(s.freq) == 16'h1 ||
                                       $past(s.freq) - s.freq == 16'h1);
    endproperty
    a_one_step: assert property (p_one_step) else $error("frequency stepped by more than one");

    property p_rise_cause;
        (s.freq > $past(s.freq)) |-> $past(s.ramp) != frl_pkg::RAMP_DOWN;
    endproperty
    a_rise_cause: assert property (p_rise_cause) else $error("rose while ramping down");

    property p_fall_cause;
        (s.freq < $past(s.freq)) |-> $past(s.ramp) != frl_pkg::RAMP_UP;
    endproperty
    a_fall_cause: assert property (p_fall_cause) else $error("fell while ramping up");

    property p_estop_no_rise;
        term.estop [*2] |-> s.freq <= $past(s.freq);
    endproperty
    a_estop_no_rise: assert property (p_estop_no_rise) else $error("rose during estop");

    property p_gen_unlimited;
        !next_s.loop.gen_limit_active |=> loop.gen_limit == $past(src.max_torque);
    endproperty
    a_gen_unlimited: assert property (p_gen_unlimited) else $error("gen limit not max");

    property p_ack_pulse;
        wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack not a single pulse");

    property p_low_band;
        (s.freq <= s.cfg.pif[15:0] && $stable(s.cfg.pil)) |=> loop.kp == $past(s.cfg.pil[15:0]);
    endproperty
    a_low_band: assert property (p_low_band) else $error("low band gain wrong");

    property p_inhibit;
        term.torque_inhibit |=> !loop.torque_mode;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("torque mode while inhibited");

    property p_time_range;
        s.cfg.estop >= frl_pkg::TIME_MIN && s.cfg.estop <= frl_pkg::TIME_MAX;
    endproperty
    a_time_range: assert property (p_time_range) else $error("estop time out of range");

endmodule

`default_nettype wire

/* File: frl_far_model.sv */
`timescale 1ns/10ps
`default_nettype none
module frl_far_model (
    // bench side
    input wire logic clock,
    input wire logic [31:0] word,
    // device side
    output var frl_pkg::frl_src_s src
);
    // sources stay inside the torque span
    always_ff @(posedge clock)
        src <= {16'(signed'(word[8:0])), 16'(signed'(word[17:9])),
            16'(signed'(word[26:18])), 16'(word[31:27]), 16'sh07D0};
endmodule
`default_nettype wire

/* File: frl_ramp_loop_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module frl_ramp_loop_tb_top;
    localparam logic [15:0] FM = 16'h0064, Z0 = 16'h0000;
    logic clock, rst_n, wb_ack_o;
    logic [31:0] word, v, q, wb_dat_o;
    logic [15:0] target_freq, output_freq;
    logic signed [15:0] speed_fb, a, b, tv [10];
    frl_pkg::frl_wb_req_s wb_req;
    frl_pkg::frl_term_s term;
    frl_pkg::frl_src_s src;
    frl_pkg::frl_loop_s loop;
    int miscompares = 0, n_checks = 0;
    frl_ramp_loop #(.CYC_PER_TENTH(10), .CYC_PER_FILT(4)) frl_ramp_loop_i (
        .clock, .rst_n, .wb_req, .wb_dat_o, .wb_ack_o, .term, .target_freq,
        .src, .speed_fb, .output_freq, .loop);
    frl_far_model frl_far_model_i (.clock, .word, .src);
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial
    begin
        #400000 miscompares++;
        wrap_up();
    end
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e)
        begin
            miscompares++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d);
        wb_req <= '{1'b1, 1'b1, we, ad, 4'hF, d};
        do
            @(posedge clock);
        while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_req <= '0;
        @(posedge clock);
    endtask
    task automatic ramp(input logic [15:0] t, input logic [15:0] g, input int e);
        int n = 0;
        target_freq <= t;
        while (output_freq !== g && n++ < e + 60)
            @(posedge clock);
        repeat (20) @(posedge clock);
        chk("freq", output_freq, g);
        chk("ramp_time", n > e - 6 && n < e + 6, 1'b1);
    endtask
    initial
    begin
        {rst_n, term, wb_req, target_freq, speed_fb} = '0;
        word = 32'h9F67AC21;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        wb(1'b0, 8'h28, 32'h0);
        chk("chan", q, 32'h0099_9000);
        wb(1'b0, 8'h7C, 32'h0);
        chk("unmapped", q, 32'h0);
        wb(1'b1, 8'h00, 32'h0000_FFFF);
        wb(1'b0, 8'h00, 32'h0);
        chk("clamp", q, {16'h0001, frl_pkg::TIME_MAX});
        for (int i = 0; i < 8; i++)
        begin
            term.mode_toggle <= i[1];
            term.torque_inhibit <= i[2];
            wb(1'b1, 8'h28, {16'h0090, 2'h0, i[1:0], 3'h0, i[0]});
            repeat (2) @(posedge clock);
            chk("mode", loop.torque_mode, (i[0] ^ i[1]) & ~i[2]);
            chk("gen_act", loop.gen_limit_active, i[1] ^ i[0]);
            if (i == 0) chk("gen_lim", loop.gen_limit, src.max_torque);
        end
        term <= '0;
        for (int c = 0; c < 10; c++)
        begin
            v = word ^ (word << 13);
            v = v ^ (v >> 17);
            word <= v ^ (v << 5);
            wb(1'b1, 8'h28, {8'h00, 4'(c), 4'(c), 8'h01});
            repeat (2) @(posedge clock);
            a = src.analog_input_one;
            b = src.analog_input_two;
            tv = '{16'sh05DC, a, b, src.analog_input_three, (a < b) ? a : b,
                (a > b) ? a : b, a - b, a + b, src.pulse_frequency_input, src.max_torque};
            chk("motor_ref", loop.motor_ref, tv[c]);
            chk("motor_lim", loop.motor_limit, tv[c]);
            chk("gen_ref", loop.gen_ref, 16'sh05DC);
        end
        wb(1'b1, 8'h1C, 32'h0064);
        for (int k = 3; k >= 0; k--)
        begin
            wb(1'b1, 8'(4 * k), {16'(10 * k + 10), 16'(20 * k + 20)});
            term.time_sel <= 2'(k);
            ramp(FM, FM, 200 * k + 200);
            ramp(Z0, Z0, 100 * k + 100);
        end
        wb(1'b1, 8'h18, 32'h0032_0032);
        ramp(FM, FM, 300);
        ramp(Z0, Z0, 150);
        wb(1'b1, 8'h18, 32'h0);
        wb(1'b1, 8'h14, 32'h000F_001E);
        term.jog <= 1'b1;
        ramp(FM, FM, 300);
        ramp(Z0, Z0, 150);
        term.jog <= 1'b0;
        wb(1'b1, 8'h20, 32'h0064_6464);
        wb(1'b1, 8'h1C, 32'h0001_0064);
        ramp(FM, FM, 400);
        wb(1'b1, 8'h1C, 32'h0064);
        wb(1'b1, 8'h30, 32'h0064_0000);
        wb(1'b1, 8'h3C, 32'h0010_0200);
        wb(1'b1, 8'h38, 32'h0030_0064);
        ramp(16'h0032, 16'h0032, 50);
        chk("kp_mid", loop.kp, 16'h0132);
        chk("ti_mid", loop.ti, 16'h0020);
        wb(1'b1, 8'h10, 32'h000F);
        term.estop <= 1'b1;
        ramp(FM, Z0, 75);
        chk("kp_low", loop.kp, 16'h0200);
        wb(1'b1, 8'h34, 32'h0);
        speed_fb <= 16'sh0123;
        repeat (2) @(posedge clock);
        chk("filt_pass", loop.speed_filt, 16'sh0123);
        wb(1'b1, 8'h34, 32'h0001);
        speed_fb <= 16'sh0323;
        repeat (2) @(posedge clock);
        chk("filt_slow", loop.speed_filt != 16'sh0323, 1'b1);
        repeat (60) @(posedge clock);
        chk("filt_end", loop.speed_filt, 16'sh0322);
        wrap_up();
    end
endmodule
`default_nettype wire
